// file: logic/qbp_consts.vh
// qbp_consts.vh: constants for the quasi-bidirectional port block
// assumes inclusion by bare name from the design files
`ifndef QBP_CONSTS_VH
`define QBP_CONSTS_VH
`define QBP_BYTE_W 8
`define QBP_P4_W 6
`define QBP_P2_W 4
`define QBP_LATCH_RST8 8'hff
`define QBP_LATCH_RST6 6'h3f
`define QBP_PWM_EN_RST 8'h00
`define QBP_ADC_CON_RST 4'h0
`define QBP_SYNC_RST4 4'hf
`define QBP_OE_RST8 8'h00
`define QBP_OE_RST6 6'h00
`define QBP_OD_LOW8 8'h00
`define QBP_RD_RST 8'h00
`define QBP_SEL_P0 3'h0
`define QBP_SEL_P1 3'h1
`define QBP_SEL_P2 3'h2
`define QBP_SEL_P3 3'h3
`define QBP_SEL_P4 3'h4
`define QBP_SEL_PWM_PIN_ENABLE_REG 3'h5
`define QBP_SEL_ADCC 3'h6
`define QBP_BOOST_CYCLES 1
`endif

// file: logic/qbp_sync.v
// qbp_sync.v: two-flop synchroniser for a group of pin inputs
// assumes pins are asynchronous to clk; reset is synchronous active low
`timescale 1ns/100ps
module qbp_sync #(
    parameter W = 8,
    parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
    clk,
    rst_b,
    async_in,
    sync_out
);
    input wire clk;
    input wire rst_b;
    input wire [W-1:0] async_in;
    output reg [W-1:0] sync_out;

    reg [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always @(posedge clk) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// file: logic/qbp_ports.v
// qbp_ports.v: parallel port block with latches, pin reads and drivers
// assumes the cpu issues one write or read per cycle on the plain ports
// assumes raw pin levels come back on the _in ports, resolved outside
// assumes pwm channel levels are already synchronous to clk
//
// Overview of operation
// - three 8-bit bidirectional ports, 24 pins
// - fourth bidirectional port of 6 bits
// - 4-bit input-only port, no latch
// - each bidirectional pin independently input or output
// - plain read returns latch AND pin
// - read-modify-write reads the latch instead
// - rmw class covers logic, bit, jump ops
// - latch one makes pin an input
// - reset loads ones into all latches
// - asynchronous pin inputs synchronised before use
// - port_zero open-drain, one floats the pin
// - quasi-bidirectional drivers on other ports
// - strong pull-up one clock on latch 0-to-1 on ports one, three and four, except port_one pins under pwm
// - port_one pins carry pwm when enabled
// - port_two pins route to adc channels
// - port_zero has no alternate function
// - port_three alternate inputs gated by latch
`timescale 1ns/100ps
`include "qbp_consts.vh"
module qbp_ports (
    clk,
    rst_b,
    wr_en,
    wr_sel,
    wr_data,
    rd_sel,
    rd_rmw,
    rd_data,
    pwm8_in,
    pwm14_in,
    p0_in,
    p0_oe,
    p0_out,
    p1_in,
    p1_oe,
    p1_out,
    p1_weak_pu,
    p3_in,
    p3_oe,
    p3_out,
    p3_weak_pu,
    p4_in,
    p4_oe,
    p4_out,
    p4_weak_pu,
    p2_in,
    adc_ch_sel,
    p3_alt_in
);
    input wire clk;
    input wire rst_b;
    input wire wr_en;
    input wire [2:0] wr_sel;
    input wire [7:0] wr_data;
    input wire [2:0] rd_sel;
    input wire rd_rmw;
    output reg [7:0] rd_data;
    input wire [5:0] pwm8_in;
    input wire [1:0] pwm14_in;
    input wire [7:0] p0_in;
    output reg [7:0] p0_oe;
    output reg [7:0] p0_out;
    input wire [7:0] p1_in;
    output reg [7:0] p1_oe;
    output reg [7:0] p1_out;
    output reg [7:0] p1_weak_pu;
    input wire [7:0] p3_in;
    output reg [7:0] p3_oe;
    output reg [7:0] p3_out;
    output reg [7:0] p3_weak_pu;
    input wire [5:0] p4_in;
    output reg [5:0] p4_oe;
    output reg [5:0] p4_out;
    output reg [5:0] p4_weak_pu;
    input wire [3:0] p2_in;
    output reg [3:0] adc_ch_sel;
    output reg [7:0] p3_alt_in;

    // output latches and alternate-function controls
    // three byte-wide latches
    reg [7:0] p0_latch_reg;
    reg [7:0] p1_latch_reg;
    reg [7:0] p3_latch_reg;
    reg [5:0] p4_latch_reg;
    reg [7:0] pwm_pin_enable_reg;
    reg [3:0] adc_channel_connect_reg;
    reg [7:0] p0_latch_next;
    reg [7:0] p1_latch_next;
    reg [7:0] p3_latch_next;
    reg [5:0] p4_latch_next;
    reg [7:0] rd_data_next;

    // synchronised pin levels
    wire [7:0] p0_sync;
    wire [7:0] p1_sync;
    wire [7:0] p3_sync;
    wire [5:0] p4_sync;
    wire [3:0] p2_sync;
    wire [7:0] pwm_src;
    wire [7:0] p1_drive;
    wire [7:0] p1_rise;
    wire [7:0] p3_rise;
    wire [5:0] p4_rise;

    // per-pin driver terms and read paths
    wire wr_hit_pwm_pin_enable_reg;
    wire wr_hit_adcc;
    wire [7:0] p1_boost;
    wire [7:0] p3_boost;
    wire [5:0] p4_boost;
    wire [7:0] p0_oe_next;
    wire [7:0] p1_oe_next;
    wire [7:0] p3_oe_next;
    wire [5:0] p4_oe_next;
    wire [7:0] p3_alt_next;
    wire [7:0] p0_pin_rd;
    wire [7:0] p1_pin_rd;
    wire [7:0] p3_pin_rd;
    wire [5:0] p4_pin_rd;
    genvar gi;

    qbp_sync #(.W(8), .RST_VAL(`QBP_LATCH_RST8)) u_sync_p0 (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(p0_in),
        .sync_out(p0_sync)
    );
    qbp_sync #(.W(8), .RST_VAL(`QBP_LATCH_RST8)) u_sync_p1 (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(p1_in),
        .sync_out(p1_sync)
    );
    qbp_sync #(.W(8), .RST_VAL(`QBP_LATCH_RST8)) u_sync_p3 (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(p3_in),
        .sync_out(p3_sync)
    );
    qbp_sync #(.W(6), .RST_VAL(`QBP_LATCH_RST6)) u_sync_p4 (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(p4_in),
        .sync_out(p4_sync)
    );
    qbp_sync #(.W(4), .RST_VAL(`QBP_SYNC_RST4)) u_sync_p2 (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(p2_in),
        .sync_out(p2_sync)
    );

    assign pwm_src = {pwm14_in, pwm8_in};

    // control register write hits
    assign wr_hit_pwm_pin_enable_reg = wr_en && (wr_sel == `QBP_SEL_PWM_PIN_ENABLE_REG);
    assign wr_hit_adcc = wr_en && (wr_sel == `QBP_SEL_ADCC);

    // latch write decode; the cpu has done any rmw itself
    always @* begin
        p0_latch_next = p0_latch_reg;
        p1_latch_next = p1_latch_reg;
        p3_latch_next = p3_latch_reg;
        p4_latch_next = p4_latch_reg;
        if (wr_en) begin
            case (wr_sel)
                `QBP_SEL_P0: p0_latch_next = wr_data;
                `QBP_SEL_P1: p1_latch_next = wr_data;
                `QBP_SEL_P3: p3_latch_next = wr_data;
                `QBP_SEL_P4: p4_latch_next = wr_data[5:0];
                default: p0_latch_next = p0_latch_reg;
            endcase
        end
    end

    // per-pin driver terms from the next latch value, one slice per bit
    generate
        for (gi = 0; gi < `QBP_BYTE_W; gi = gi + 1) begin : g_pin
            assign p1_rise[gi] = p1_latch_next[gi] & ~p1_latch_reg[gi];
            assign p3_rise[gi] = p3_latch_next[gi] & ~p3_latch_reg[gi];
            assign p1_drive[gi] = pwm_pin_enable_reg[gi] ? pwm_src[gi] : p1_latch_next[gi];
            // no strong high while pwm owns the pin
            assign p1_boost[gi] = p1_rise[gi] & ~pwm_pin_enable_reg[gi];
            assign p3_boost[gi] = p3_rise[gi];
            assign p0_oe_next[gi] = ~p0_latch_next[gi];
            assign p1_oe_next[gi] = ~p1_drive[gi] | p1_boost[gi];
            assign p3_oe_next[gi] = ~p3_latch_next[gi] | p3_boost[gi];
            assign p3_alt_next[gi] = p3_sync[gi] | ~p3_latch_reg[gi];
            if (gi < `QBP_P4_W) begin : g_p4
                assign p4_rise[gi] = p4_latch_next[gi] & ~p4_latch_reg[gi];
                assign p4_boost[gi] = p4_rise[gi];
                assign p4_oe_next[gi] = ~p4_latch_next[gi] | p4_boost[gi];
            end
        end
    endgenerate

    assign p0_pin_rd = p0_latch_reg & p0_sync;
    assign p1_pin_rd = p1_latch_reg & p1_sync;
    assign p3_pin_rd = p3_latch_reg & p3_sync;
    assign p4_pin_rd = p4_latch_reg & p4_sync;

    // read mux: rmw sees latches, plain reads see latch and pin
    always @* begin
        rd_data_next = `QBP_RD_RST;
        case (rd_sel)
            `QBP_SEL_P0: rd_data_next = rd_rmw ? p0_latch_reg : p0_pin_rd;
            `QBP_SEL_P1: rd_data_next = rd_rmw ? p1_latch_reg : p1_pin_rd;
            `QBP_SEL_P3: rd_data_next = rd_rmw ? p3_latch_reg : p3_pin_rd;
            `QBP_SEL_P4: rd_data_next = rd_rmw ? {2'h0, p4_latch_reg} : {2'h0, p4_pin_rd};
            `QBP_SEL_P2: rd_data_next = {4'h0, p2_sync};
            `QBP_SEL_PWM_PIN_ENABLE_REG: rd_data_next = pwm_pin_enable_reg;
            `QBP_SEL_ADCC: rd_data_next = {4'h0, adc_channel_connect_reg};
            default: rd_data_next = `QBP_RD_RST;
        endcase
    end

    // port output latches
    always @(posedge clk) begin
        if (!rst_b) begin
            p0_latch_reg <= `QBP_LATCH_RST8;
            p1_latch_reg <= `QBP_LATCH_RST8;
            p3_latch_reg <= `QBP_LATCH_RST8;
            p4_latch_reg <= `QBP_LATCH_RST6;
        end else begin
            p0_latch_reg <= p0_latch_next;
            p1_latch_reg <= p1_latch_next;
            p3_latch_reg <= p3_latch_next;
            p4_latch_reg <= p4_latch_next;
        end
    end

    // alternate-function control registers
    always @(posedge clk) begin
        if (!rst_b) begin
            pwm_pin_enable_reg <= `QBP_PWM_EN_RST;
            adc_channel_connect_reg <= `QBP_ADC_CON_RST;
        end else begin
            if (wr_hit_pwm_pin_enable_reg) begin
                pwm_pin_enable_reg <= wr_data;
            end
            if (wr_hit_adcc) begin
                adc_channel_connect_reg <= wr_data[3:0];
            end
        end
    end

    // registered read data, one cycle after the select
    always @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= `QBP_RD_RST;
        end else begin
            rd_data <= rd_data_next;
        end
    end

    // port_zero and port_one drivers, registered
    always @(posedge clk) begin
        if (!rst_b) begin
            p0_oe <= `QBP_OE_RST8;
            p0_out <= `QBP_OD_LOW8;
            p1_oe <= `QBP_OE_RST8;
            p1_out <= `QBP_LATCH_RST8;
            p1_weak_pu <= `QBP_LATCH_RST8;
        end else begin
            p0_oe <= p0_oe_next;
            p0_out <= `QBP_OD_LOW8;
            p1_oe <= p1_oe_next;
            p1_out <= p1_drive;
            p1_weak_pu <= p1_drive;
        end
    end

    // port_three and port_four drivers, registered
    always @(posedge clk) begin
        if (!rst_b) begin
            p3_oe <= `QBP_OE_RST8;
            p3_out <= `QBP_LATCH_RST8;
            p3_weak_pu <= `QBP_LATCH_RST8;
            p4_oe <= `QBP_OE_RST6;
            p4_out <= `QBP_LATCH_RST6;
            p4_weak_pu <= `QBP_LATCH_RST6;
        end else begin
            p3_oe <= p3_oe_next;
            p3_out <= p3_latch_next;
            p3_weak_pu <= p3_latch_next;
            p4_oe <= p4_oe_next;
            p4_out <= p4_latch_next;
            p4_weak_pu <= p4_latch_next;
        end
    end

    // alternate routing toward the adc and port_three functions
    always @(posedge clk) begin
        if (!rst_b) begin
            adc_ch_sel <= `QBP_ADC_CON_RST;
            p3_alt_in <= `QBP_LATCH_RST8;
        end else begin
            adc_ch_sel <= adc_channel_connect_reg;
            p3_alt_in <= p3_alt_next;
        end
    end
endmodule

// file: verification/qbp_pin_model.sv
// qbp_pin_model.sv: external devices on one bidirectional port
// assumes oe high means the block drives out onto the pin
`timescale 1ns/100ps
module qbp_pin_model #(
    parameter W = 8
) (
    input wire [W-1:0] oe,
    input wire [W-1:0] out,
    input wire [W-1:0] ext,
    output wire [W-1:0] pin
);
    // device drive wins, else external level
    assign pin = (oe & out) | (~oe & ext);
endmodule

// file: verification/qbp_checker.sv
// qbp_checker.sv: assertions on the port block pins and reads
// assumes bind onto qbp_ports, rising clk, synchronous low rst_b
`timescale 1ns/100ps
module qbp_checker (
    input wire clk, rst_b, wr_en, rd_rmw,
    input wire [2:0] wr_sel, rd_sel,
    input wire [7:0] wr_data, rd_data, p0_oe, p0_out, p1_oe, p1_out, p3_oe, p3_out, p3_alt_in,
    input wire [5:0] p4_oe, p4_out,
    input wire [3:0] adc_ch_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // pin drive and read relations
    a_p0_low_only: assert property (p0_out == 8'h00)
        else $error("p0 drove high");
    a_p0_pull_down: assert property (wr_en && wr_sel == 3'h0 |=> p0_oe == ~$past(wr_data))
        else $error("p0 drive wrong");
    a_p1_boost_once: assert property ((p1_oe & p1_out & $past(p1_oe & p1_out)) == 8'h00)
        else $error("p1 boost too long");
    a_p3_pull_down: assert property (wr_en && wr_sel == 3'h3 |=> (p3_oe & ~p3_out) == ~$past(wr_data))
        else $error("p3 drive wrong");
    a_p4_pull_down: assert property (wr_en && wr_sel == 3'h4 |=> (p4_oe & ~p4_out) == ~$past(wr_data[5:0]))
        else $error("p4 drive wrong");
    a_rmw_latch_read: assert property (rd_sel == 3'h3 && rd_rmw |=> rd_data == ~$past(p3_oe & ~p3_out))
        else $error("rmw read wrong");
    a_adc_route: assert property (wr_en && wr_sel == 3'h6 |-> ##2 adc_ch_sel == $past(wr_data[3:0], 2))
        else $error("adc select wrong");
    a_narrow_read: assert property (rd_sel == 3'h2 |=> rd_data[7:4] == 4'h0)
        else $error("p2 upper bits set");
    a_alt_gated: assert property (((p3_oe & ~p3_out) == 8'hff) [*2] |-> p3_alt_in == 8'hff)
        else $error("p3 alt not gated");
    // main scenarios
    c_boost: cover property (p1_oe[0] && p1_out[0]);
    c_rmw: cover property (rd_rmw && rd_sel == 3'h3);
    c_adc: cover property (wr_en && wr_sel == 3'h6);
    c_alt_pass: cover property (p3_alt_in == 8'h5a);
endmodule
bind qbp_ports qbp_checker u_qbp_checker (.*);

// file: verification/qbp_ports_tb_top.sv
// qbp_ports_tb_top.sv: directed tests of the port block
// assumes pin models resolve each port from its drive enables
`timescale 1ns/100ps
module qbp_ports_tb_top;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg wr_en = 1'b0;
    reg rd_rmw = 1'b0;
    reg [2:0] wr_sel = 3'h0;
    reg [2:0] rd_sel = 3'h0;
    reg [7:0] wr_data = 8'h00;
    reg [7:0] ext = 8'hff;
    reg [5:0] pwm8_in = 6'h3f;
    reg [1:0] pwm14_in = 2'h3;
    reg [3:0] p2_in = 4'h0;
    integer num_errors = 0;
    integer n_tests = 0;
    wire [7:0] rd_data, p0_oe, p0_out, p0_in, p1_oe, p1_out, p1_in, p1_weak_pu;
    wire [7:0] p3_oe, p3_out, p3_in, p3_weak_pu, p3_alt_in;
    wire [5:0] p4_oe, p4_out, p4_in, p4_weak_pu;
    wire [3:0] adc_ch_sel;
    qbp_ports dut (.*);
    qbp_pin_model m0 (.oe(p0_oe), .out(p0_out), .ext(ext), .pin(p0_in));
    qbp_pin_model m1 (.oe(p1_oe), .out(p1_out), .ext(ext), .pin(p1_in));
    qbp_pin_model m3 (.oe(p3_oe), .out(p3_out), .ext(ext), .pin(p3_in));
    qbp_pin_model #(.W(6)) m4 (.oe(p4_oe), .out(p4_out), .ext(ext[5:0]), .pin(p4_in));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [2:0] sel, input [7:0] data);
        begin
            @(negedge clk);
            wr_en = 1'b1;
            wr_sel = sel;
            wr_data = data;
            @(negedge clk);
            wr_en = 1'b0;
        end
    endtask
    task rd(input [2:0] sel, input rmw, input [7:0] exp);
        begin
            @(negedge clk);
            rd_sel = sel;
            rd_rmw = rmw;
            @(negedge clk);
            chk(rd_data, exp);
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // directed sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        rd(3'h0, 1'b1, 8'hff);
        rd(3'h4, 1'b1, 8'h3f);
        chk(p1_oe, 8'h00);
        ext = 8'h5a;
        wr(3'h0, 8'h0f);
        chk(p0_oe, 8'hf0);
        rd(3'h0, 1'b0, 8'h0a);
        rd(3'h0, 1'b1, 8'h0f);
        wr(3'h1, 8'h00);
        wr(3'h1, 8'hff);
        chk(p1_oe & p1_out, 8'hff);
        @(negedge clk);
        chk(p1_oe, 8'h00);
        chk(p1_weak_pu, 8'hff);
        wr(3'h1, 8'hff);
        chk(p1_oe, 8'h00);
        wr(3'h3, 8'ha5);
        chk(p3_weak_pu, 8'ha5);
        ext = 8'hff;
        repeat (3) @(negedge clk);
        rd(3'h3, 1'b0, 8'ha5);
        chk(p3_alt_in, 8'hff);
        ext = 8'h00;
        repeat (3) @(negedge clk);
        rd(3'h3, 1'b0, 8'h00);
        rd(3'h3, 1'b1, 8'ha5);
        chk(p3_alt_in, 8'h5a);
        wr(3'h3, 8'h00);
        @(negedge clk);
        chk(p3_alt_in, 8'hff);
        wr(3'h4, 8'hea);
        chk({2'h0, p4_weak_pu}, 8'h2a);
        wr(3'h2, 8'h00);
        rd(3'h4, 1'b1, 8'h2a);
        p2_in = 4'h9;
        repeat (3) @(negedge clk);
        rd(3'h2, 1'b0, 8'h09);
        wr(3'h6, 8'hf5);
        @(negedge clk);
        chk({4'h0, adc_ch_sel}, 8'h05);
        pwm8_in = 6'h3e;
        wr(3'h5, 8'h81);
        @(negedge clk);
        chk(p1_oe & ~p1_out, 8'h01);
        pwm8_in = 6'h3f;
        pwm14_in = 2'h1;
        repeat (2) @(negedge clk);
        chk(p1_oe & ~p1_out, 8'h80);
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        rd(3'h1, 1'b1, 8'hff);
        chk(p1_oe, 8'h00);
        results;
    end
    // watchdog for a hung run
    initial begin
        repeat (2000) @(posedge clk);
        num_errors = num_errors + 1;
        results;
    end
endmodule
